// [design/osp_params.svh]
// offsets, field positions, reset values and timing counts of the one-shot counter
`ifndef OSP_PARAMS_SVH
`define OSP_PARAMS_SVH

`define OSP_OFS_GLOBAL   8'h00
`define OSP_OFS_STATUS   8'h04
`define OSP_OFS_TRIG     8'h1C
`define OSP_OFS_CTRL     8'h20
`define OSP_OFS_CONST_A  8'h24
`define OSP_OFS_CONST_B  8'h28
`define OSP_OFS_READBACK 8'h2C

`define OSP_MODE_HI      2
`define OSP_MODE_LO      0
`define OSP_MODE_ONESHOT 3'h7
`define OSP_POL_BIT      3
`define OSP_GATE_HI      5
`define OSP_GATE_LO      4
`define OSP_XCLK_HI      7
`define OSP_XCLK_LO      6
`define OSP_TRIG_HI      9
`define OSP_TRIG_LO      8
`define OSP_CSRC_HI      12
`define OSP_CSRC_LO      10
`define OSP_DEB_BIT      13
`define OSP_SIZE_BIT     14
`define OSP_IEN_BIT      15

`define OSP_SEL_ACT_LO   2'h1
`define OSP_SEL_ACT_HI   2'h2
`define OSP_CSRC_EXT     3'h5
`define OSP_CSRC_20M     3'h4
`define OSP_CTRL_RST     16'h0000
`define OSP_PRESC_ALL    5'h1F

`define OSP_CORE_MHZ     40
`define OSP_ZERO_NS      50
`define OSP_DEB_NS       2400
`define OSP_ZERO_CYC     ((`OSP_ZERO_NS * `OSP_CORE_MHZ + 999) / 1000)
`define OSP_DEB_CYC      ((`OSP_DEB_NS * `OSP_CORE_MHZ) / 1000)

`endif

// [design/osp_pkg.sv]
// types shared by the one-shot counter
package osp_pkg;

  typedef enum logic [2:0] {
    OSP_IDLE,
    OSP_DELAY,
    OSP_DET_A,
    OSP_PULSE,
    OSP_DET_B
  } osp_state_t;

endpackage

// [design/osp_counter.sv]
// one-shot pulse counter channel with an ahb-lite register slave
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`include "osp_params.svh"

module osp_counter #(
  parameter int CNT_W = 32
) (
  input  wire logic              core_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              ce_in,
  input  wire logic              hsel_in,
  input  wire logic [31:0]       haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic              hready_in,
  input  wire logic [31:0]       hwdata_in,
  output logic      [31:0]       hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  input  wire logic              gate_off_input_in,
  input  wire logic              external_clock_input_in,
  input  wire logic              ext_trigger_in,
  output logic                   pulse_out,
  output logic                   irq_out
);

  localparam logic [7:0] ZERO_CYC = 8'(`OSP_ZERO_CYC);
  localparam logic [7:0] DEB_CYC  = 8'(`OSP_DEB_CYC);

  // constants are cut to 16 bits unless the pair is joined
  function automatic logic [CNT_W-1:0] fit(
    input logic [CNT_W-1:0] v,
    input logic             wide
  );
    logic [CNT_W-1:0] r;
    r = v;
    if (!wide) begin
      r = {{(CNT_W-16){1'b0}}, v[15:0]};
    end
    return r;
  endfunction

  // a two-bit polarity select is live only for 01 and 10
  function automatic logic sel_on(input logic [1:0] s);
    return (s == `OSP_SEL_ACT_LO) || (s == `OSP_SEL_ACT_HI);
  endfunction

  // ---------------- registers ----------------
  logic [15:0]      ctrl_q;
  logic             glob_ien_q;
  logic [CNT_W-1:0] const_a_q;
  logic [CNT_W-1:0] const_b_q;
  logic             pend_q;
  logic [31:0]      rdata_q;
  logic             dp_wr_q;
  logic [7:0]       dp_addr_q;

  // ---------------- counter state ----------------
  osp_pkg::osp_state_t state_q;
  osp_pkg::osp_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [7:0]       zc_q;
  logic [7:0]       zc_d;
  logic             act_q;
  logic             act_d;
  logic [4:0]       presc_q;
  logic             xclk_q;
  logic             xclk_prev_q;
  logic [1:0]       samp_q;
  logic [1:0]       filt_q;
  logic [7:0]       deb_q [2];
  logic             trig_prev_q;

  // ---------------- bus decode ----------------
  wire addr_ok   = hsel_in & hready_in & htrans_in[1] & ce_in;
  wire [7:0] aof = haddr_in[7:0];
  wire dp_wr     = dp_wr_q & ce_in;
  wire wr_glob   = dp_wr & (dp_addr_q == `OSP_OFS_GLOBAL);
  wire wr_stat   = dp_wr & (dp_addr_q == `OSP_OFS_STATUS);
  wire wr_trig   = dp_wr & (dp_addr_q == `OSP_OFS_TRIG);
  wire wr_ctrl   = dp_wr & (dp_addr_q == `OSP_OFS_CTRL);
  wire wr_ca     = dp_wr & (dp_addr_q == `OSP_OFS_CONST_A);
  wire wr_cb     = dp_wr & (dp_addr_q == `OSP_OFS_CONST_B);

  // ---------------- control fields ----------------
  wire [2:0] mode   = ctrl_q[`OSP_MODE_HI:`OSP_MODE_LO];
  wire oneshot      = (mode == `OSP_MODE_ONESHOT);
  wire pol_hi       = ctrl_q[`OSP_POL_BIT];
  wire [1:0] gsel   = ctrl_q[`OSP_GATE_HI:`OSP_GATE_LO];
  wire [1:0] xsel   = ctrl_q[`OSP_XCLK_HI:`OSP_XCLK_LO];
  wire [1:0] tsel   = ctrl_q[`OSP_TRIG_HI:`OSP_TRIG_LO];
  wire [2:0] csrc   = ctrl_q[`OSP_CSRC_HI:`OSP_CSRC_LO];
  wire deb_on       = ctrl_q[`OSP_DEB_BIT];
  wire wide         = ctrl_q[`OSP_SIZE_BIT];
  wire ien          = ctrl_q[`OSP_IEN_BIT];

  // ---------------- clock source ----------------
  // internal rates are 40MHz divided by 32, 16, 8, 4 or 2
  wire [4:0] pmask  = `OSP_PRESC_ALL >> csrc;
  wire int_tick     = (csrc <= `OSP_CSRC_20M)
                    & ((presc_q & pmask) == pmask);
  wire ext_tick     = (csrc == `OSP_CSRC_EXT) & sel_on(xsel)
                    & xclk_q & ~xclk_prev_q;
  wire tick20       = presc_q[0];

  // ---------------- gate and trigger ----------------
  wire gate_lvl     = filt_q[0];
  wire gate_run     = (gsel == `OSP_SEL_ACT_LO) ? ~gate_lvl :
                      (gsel == `OSP_SEL_ACT_HI) ?  gate_lvl :
                      1'b1;
  wire step         = (int_tick | ext_tick) & gate_run;
  wire trig_lvl     = filt_q[1];
  wire ext_trig     = (tsel == `OSP_SEL_ACT_LO) ?
                        (trig_prev_q & ~trig_lvl) :
                      (tsel == `OSP_SEL_ACT_HI) ?
                        (~trig_prev_q & trig_lvl) :
                      1'b0;
  wire trigger      = wr_trig | ext_trig;

  // ---------------- edges of the pulse ----------------
  wire edge_ev      = act_d ^ act_q;
  wire irq_set      = edge_ev & ien & glob_ien_q;
  wire irq_clr      = (wr_stat & hwdata_in[0])
                    | (wr_ctrl & ~hwdata_in[`OSP_IEN_BIT]);

  // ---------------- one-shot sequencer ----------------
  // a trigger while busy is ignored; retrigger timing is the
  // caller's duty and dropping it keeps the pulse whole
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    zc_d    = zc_q;
    act_d   = act_q;
    case (state_q)
      osp_pkg::OSP_IDLE: begin
        act_d = 1'b0;
        if (trigger && oneshot) begin
          cnt_d   = fit(const_a_q, wide);
          state_d = osp_pkg::OSP_DELAY;
        end
      end
      osp_pkg::OSP_DELAY: begin
        if (cnt_q == '0) begin
          zc_d    = 8'h01;
          state_d = osp_pkg::OSP_DET_A;
        end else if (step) begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      osp_pkg::OSP_DET_A: begin
        // zero detection costs a fixed 50ns
        if (zc_q >= ZERO_CYC) begin
          act_d   = 1'b1;
          cnt_d   = fit(const_b_q, wide);
          state_d = osp_pkg::OSP_PULSE;
        end else begin
          zc_d = zc_q + 8'h01;
        end
      end
      osp_pkg::OSP_PULSE: begin
        if (cnt_q == '0) begin
          zc_d    = 8'h01;
          state_d = osp_pkg::OSP_DET_B;
        end else if (step) begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      osp_pkg::OSP_DET_B: begin
        if (zc_q >= ZERO_CYC) begin
          act_d   = 1'b0;
          state_d = osp_pkg::OSP_IDLE;
        end else begin
          zc_d = zc_q + 8'h01;
        end
      end
      default: begin
        act_d   = 1'b0;
        state_d = osp_pkg::OSP_IDLE;
      end
    endcase
    // leaving one-shot mode abandons a running pulse
    if (!oneshot) begin
      act_d   = 1'b0;
      state_d = osp_pkg::OSP_IDLE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_q <= osp_pkg::OSP_IDLE;
      cnt_q   <= '0;
      zc_q    <= 8'h00;
      act_q   <= 1'b0;
    end else if (ce_in) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      zc_q    <= zc_d;
      act_q   <= act_d;
    end
  end

  // ---------------- prescaler and input sampling ----------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      presc_q     <= 5'h00;
      xclk_q      <= 1'b0;
      xclk_prev_q <= 1'b0;
    end else if (ce_in) begin
      presc_q     <= presc_q + 5'h01;
      xclk_q      <= external_clock_input_in;
      xclk_prev_q <= xclk_q;
    end
  end

  // gate and trigger are taken on 20MHz ticks only, so they
  // need not line up with the counting clock
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      samp_q <= 2'b00;
    end else if (ce_in && tick20) begin
      samp_q <= {ext_trigger_in, gate_off_input_in};
    end
  end

  // a changed level must hold past 2.4us to be accepted
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      filt_q      <= 2'b00;
      deb_q[0]    <= 8'h00;
      deb_q[1]    <= 8'h00;
      trig_prev_q <= 1'b0;
    end else if (ce_in) begin
      trig_prev_q <= filt_q[1];
      for (int i = 0; i < 2; i++) begin
        if (!deb_on || samp_q[i] == filt_q[i]) begin
          filt_q[i] <= samp_q[i];
          deb_q[i]  <= 8'h00;
        end else if (deb_q[i] >= DEB_CYC) begin
          filt_q[i] <= samp_q[i];
          deb_q[i]  <= 8'h00;
        end else begin
          deb_q[i] <= deb_q[i] + 8'h01;
        end
      end
    end
  end

  // ---------------- bus slave ----------------
  wire [31:0] status_w = {29'h0, state_q != osp_pkg::OSP_IDLE,
                          act_q, pend_q};
  wire [31:0] rd_mux =
    (aof == `OSP_OFS_GLOBAL)   ? {31'h0, glob_ien_q} :
    (aof == `OSP_OFS_STATUS)   ? status_w :
    (aof == `OSP_OFS_CTRL)     ? {16'h0, ctrl_q} :
    (aof == `OSP_OFS_CONST_A)  ? 32'(const_a_q) :
    (aof == `OSP_OFS_CONST_B)  ? 32'(const_b_q) :
    (aof == `OSP_OFS_READBACK) ? 32'(cnt_q) :
    32'h0000_0000;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end else if (ce_in) begin
      dp_wr_q   <= addr_ok & hwrite_in;
      dp_addr_q <= aof;
      if (addr_ok && !hwrite_in) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctrl_q     <= `OSP_CTRL_RST;
      glob_ien_q <= 1'b0;
      const_a_q  <= '0;
      const_b_q  <= '0;
    end else if (ce_in) begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata_in[15:0];
      end
      if (wr_glob) begin
        glob_ien_q <= hwdata_in[0];
      end
      if (wr_ca) begin
        const_a_q <= hwdata_in[CNT_W-1:0];
      end
      if (wr_cb) begin
        const_b_q <= hwdata_in[CNT_W-1:0];
      end
    end
  end

  // a new edge wins over a clear in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pend_q <= 1'b0;
    end else if (ce_in) begin
      if (irq_set) begin
        pend_q <= 1'b1;
      end else if (irq_clr) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ---------------- outputs ----------------
  // wait states while frozen keep the master from losing a beat
  assign hreadyout_out = ce_in;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = rdata_q;
  assign irq_out       = pend_q;
  // idle level is high (pull-up) only with the polarity bit clear; low when it is set
  assign pulse_out     = pol_hi ? act_q : ~act_q;

endmodule

// [verification/osp_counter_assertions.sv]
// port-level checks of the one-shot counter
`timescale 1ns/10ps
`include "osp_params.svh"
module osp_chk (
  input wire logic        core_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        ce_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        pulse_out,
  input wire logic        irq_out
);
  logic        ap_q;
  logic [7:0]  a_q;
  logic [15:0] ctl_q;
  logic        glb_q;
  wire         wd = ap_q && hreadyout_out;
  // either way of dropping a pending interrupt
  wire         clr = wd && (a_q == `OSP_OFS_STATUS ? hwdata_in[0] :
                     a_q == `OSP_OFS_CTRL && !hwdata_in[15]);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ap_q  <= 1'b0;
      ctl_q <= `OSP_CTRL_RST;
      glb_q <= 1'b0;
    end else begin
      if (hready_in) begin
        ap_q <= hsel_in && htrans_in[1] && hwrite_in && ce_in;
        a_q  <= haddr_in[7:0];
      end
      if (wd && a_q == `OSP_OFS_CTRL) begin
        ctl_q <= hwdata_in[15:0];
      end
      if (wd && a_q == `OSP_OFS_GLOBAL) begin
        glb_q <= hwdata_in[0];
      end
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_resp_okay: assert property (hresp_out == 1'b0)
    else $error("bus response not okay");
  a_ready_ce: assert property (hreadyout_out == ce_in)
    else $error("ready does not follow clock enable");
  a_edge_irq: assert property (
    $changed(pulse_out) && $stable(ctl_q) && ctl_q[15] && glb_q
    |-> ##[0:2] irq_out) else $error("pulse edge raised no interrupt");
  a_irq_hold: assert property (irq_out && !clr |=> irq_out)
    else $error("pending interrupt dropped");
  a_clear_drop: assert property (
    clr |=> !$stable(pulse_out) || !irq_out)
    else $error("interrupt survived a clear");
  a_off_quiet: assert property (
    !ctl_q[15] && !$past(ctl_q[15]) |-> !irq_out)
    else $error("interrupt while disabled");
  a_idle_level: assert property (
    (ctl_q[2:0] != 3'h7)[*3] |-> pulse_out == !ctl_q[3])
    else $error("output not at inactive level");
  a_zero_det: assert property (
    $changed(pulse_out) && $stable(ctl_q) |=> $stable(pulse_out))
    else $error("output level held under two cycles");

  c_irq: cover property ($rose(irq_out));
  c_pulse: cover property ($fell(pulse_out));
  c_clear: cover property (clr && irq_out);
endmodule

// [verification/osp_field_model.sv]
// field-side model: gate level, external clock and trigger lines
`timescale 1ns/10ps
module osp_field_model (
  input  wire logic run_clk_in,
  input  wire logic trig_in,
  input  wire logic trig_hi_in,
  input  wire logic stop_in,
  input  wire logic gate_hi_in,
  output logic      gate_out,
  output logic      xclk_out,
  output logic      trig_out
);
  // the bench raises a trigger only once the previous pulse is over
  assign trig_out = trig_hi_in ? trig_in : !trig_in;
  assign gate_out = stop_in ^ gate_hi_in;
  // 150ns period stays under the 8MHz ceiling; still while not running
  initial xclk_out = 1'b0;
  always begin
    wait (run_clk_in);
    #75 xclk_out = ~xclk_out;
  end
endmodule

// [verification/testbench.sv]
// self-checking bench for the one-shot pulse counter
`timescale 1ns/10ps
`include "osp_params.svh"
module testbench;
  logic        clk, rst, hsel, hwr, tact, thi, stop, ghi, xrun;
  logic [1:0]  htr;
  logic [31:0] hadr, hwd, r;
  wire  [31:0] hrd;
  wire         rdy, resp, pls, irq, gate, xclk, trig;
  int          miscompares, checked, seed, i, a, q[$];
  logic [15:0] ctl;
  logic        ce;
  logic [2:0]  hsz;

  osp_counter dut (.core_clk_in(clk), .sys_rst_in(rst), .ce_in(ce),
    .hsel_in(hsel), .haddr_in(hadr), .htrans_in(htr), .hwrite_in(hwr),
    .hsize_in(hsz), .hready_in(rdy), .hwdata_in(hwd), .hrdata_out(hrd),
    .hreadyout_out(rdy), .hresp_out(resp), .gate_off_input_in(gate),
    .external_clock_input_in(xclk), .ext_trigger_in(trig),
    .pulse_out(pls), .irq_out(irq));
  osp_field_model far (.run_clk_in(xrun), .trig_in(tact), .trig_hi_in(thi),
    .stop_in(stop), .gate_hi_in(ghi), .gate_out(gate), .xclk_out(xclk),
    .trig_out(trig));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #500000;
    miscompares++;
    summarize();
  end

  task summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
           output logic [31:0] rd);
    @(posedge clk);
    hadr <= {24'h0, ad};
    hwr <= w;
    htr <= 2'h2;
    hsel <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    htr <= 2'h0;
    hwd <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrd;
  endtask

  task wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, ad, d, x);
  endtask

  // expected delay and width come from the queue; t is the slack
  task shot(input int t);
    int d, w, n;
    d = q.pop_front();
    w = q.pop_front();
    n = 0;
    while (pls !== ctl[3] && n < d + t) begin
      @(negedge clk);
      n++;
    end
    if (w == 0) begin
      chk(pls, !ctl[3]);
    end else begin
      chk(pls, ctl[3]);
      chk(n + t >= d, 1);
      n = 0;
      while (pls === ctl[3] && n < w + t) begin
        @(negedge clk);
        n++;
      end
      chk(n + t >= w && n < w + t, 1);
    end
  endtask

  initial begin
    {hsel, hwr, tact, thi, stop, ghi, xrun} = '0;
    htr = 2'h0;
    hadr = '0;
    hwd = '0;
    ctl = '0;
    ce = 1'b1;
    hsz = 3'h2;
    seed = 13;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, `OSP_OFS_CTRL, 0, r);
    chk(r, 0);
    chk(pls, 1);
    chk(irq, 0);
    bus(1'b0, 8'h40, 0, r);
    chk(r, 0);
    // a frozen block must stall the bus rather than lose a beat
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    chk(rdy, 0);
    ce <= 1'b1;
    @(posedge clk);
    chk(rdy, 1);
    wr(`OSP_OFS_GLOBAL, 1);
    wr(`OSP_OFS_CONST_B, 3);
    $display("reset test done");
    for (i = 0; i < 5; i++) begin
      a = ($random(seed) & 3) + 1;
      ctl = 16'h8007 | 16'(i << 10) | 16'((i & 1) << 3);
      wr(`OSP_OFS_CONST_A, 32'(a) | 32'h30000);
      wr(`OSP_OFS_CTRL, 32'(ctl));
      wr(`OSP_OFS_TRIG, 0);
      q.push_back(a * (32 >> i) + 3);
      q.push_back(3 * (32 >> i) + 2);
      shot((32 >> i) + 1);
      chk(irq, 1);
      if (i == 4) wr(`OSP_OFS_CTRL, 32'(ctl & 16'h7FFF));
      else wr(`OSP_OFS_STATUS, 1);
      @(negedge clk);
      chk(irq, 0);
      $display("clock source %0d done", i);
    end
    wr(`OSP_OFS_CONST_A, 5);
    for (i = 0; i < 3; i++) begin
      ctl = 16'h1007 | 16'(i << 8);
      wr(`OSP_OFS_CTRL, 32'(ctl));
      thi <= i[1];
      repeat (8) @(posedge clk);
      tact <= 1'b1;
      q.push_back(17);
      q.push_back(i == 0 ? 0 : 8);
      shot(5);
      tact <= 1'b0;
      $display("trigger code %0d done", i);
    end
    for (i = 1; i < 3; i++) begin
      ghi <= i[1];
      stop <= 1'b1;
      ctl = 16'h1007 | 16'(i << 4);
      wr(`OSP_OFS_CTRL, 32'(ctl));
      wr(`OSP_OFS_TRIG, 0);
      q.push_back(60);
      q.push_back(0);
      shot(0);
      stop <= 1'b0;
      q.push_back(17);
      q.push_back(8);
      shot(5);
      $display("gate code %0d done", i);
    end
    xrun <= 1'b1;
    ctl = 16'h1447;
    wr(`OSP_OFS_CTRL, 32'(ctl));
    wr(`OSP_OFS_TRIG, 0);
    q.push_back(35);
    q.push_back(20);
    shot(8);
    xrun <= 1'b0;
    ctl = 16'h1006;
    wr(`OSP_OFS_CTRL, 32'(ctl));
    wr(`OSP_OFS_TRIG, 0);
    q.push_back(60);
    q.push_back(0);
    shot(0);
    $display("clock and mode tests done");
    ctl = 16'h3207;
    wr(`OSP_OFS_CTRL, 32'(ctl));
    thi <= 1'b1;
    repeat (8) @(posedge clk);
    tact <= 1'b1;
    repeat (96) @(posedge clk);
    tact <= 1'b0;
    q.push_back(100);
    q.push_back(0);
    shot(0);
    tact <= 1'b1;
    q.push_back(114);
    q.push_back(8);
    shot(6);
    tact <= 1'b0;
    $display("debounce test done");
    summarize();
  end
endmodule

bind osp_counter osp_chk u_chk (.core_clk_in(core_clk_in),
  .sys_rst_in(sys_rst_in), .ce_in(ce_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hready_in(hready_in), .hwdata_in(hwdata_in),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .pulse_out(pulse_out), .irq_out(irq_out));
